// >>> bench/serial_port_strap_sampler_tb.sv
// Self-checking bench for the serial port strap sampler
`timescale 1ns/1ps
`include "strap_params.svh"
module serial_port_strap_sampler_tb;
   import strap_pkg::*;
   localparam int PAIRS = 8;
   logic             ref_clk_i = 1'b0;
   logic             reset_i = 1'b1;
   logic             self_reset_done_i = 1'b0;
   logic             test_mode_i = 1'b0;
   logic [3:0]       addr_i = 4'h0;
   logic [31:0]      wdata_i = 32'h0000_0000;
   logic             wr_i = 1'b0;
   logic             rd_i = 1'b0;
   logic [1:0]       rate_cfg = 2'h2;
   logic             rx_cfg = 1'b0;
   logic             tx_cfg = 1'b0;
   logic [PAIRS-1:0] width_cfg = 8'h00;
   logic             disturb = 1'b0;
   logic [1:0]       rate_pin, strap_o, strap_oe, port_rate_o, code, exp_rate;
   logic             rx_pin, tx_pin, straps_valid_o;
   logic [PAIRS-1:0] width_pin, rx_rev, tx_rev, four_lane_o, w;
   logic [31:0]      rdata_o;
   logic [7:0]       width_tbl [4] = '{8'h5a, 8'ha5, 8'h0f, 8'hf0};
   int               err_total = 0;
   int               checked = 0;
   int               n;
   initial begin
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   serial_port_strap_sampler #(.PAIRS(PAIRS)) serial_port_strap_sampler_inst (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .self_reset_done_i(self_reset_done_i),
      .test_mode_i(test_mode_i), .port_line_rate_strap_i(rate_pin),
      .port_line_rate_strap_o(strap_o), .port_line_rate_strap_oe_o(strap_oe),
      .rx_lane_reverse_strap_i(rx_pin), .tx_lane_reverse_strap_i(tx_pin),
      .port_width_strap_i(width_pin), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .port_rate_o(port_rate_o),
      .rx_lane_reverse_o(rx_rev), .tx_lane_reverse_o(tx_rev),
      .four_lane_o(four_lane_o), .straps_valid_o(straps_valid_o));
   strap_board_model #(.PAIRS(PAIRS), .HOLD(10)) strap_board_model_inst (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .rate_cfg_i(rate_cfg), .rx_cfg_i(rx_cfg),
      .tx_cfg_i(tx_cfg), .width_cfg_i(width_cfg), .disturb_i(disturb),
      .rate_drv_i(strap_o), .rate_oe_i(strap_oe), .rate_pin_o(rate_pin),
      .rx_pin_o(rx_pin), .tx_pin_o(tx_pin), .width_pin_o(width_pin));
   // ---------------------------------------------------------------
   // Checking and bus tasks
   // ---------------------------------------------------------------
   task automatic print_verdict;
      if (err_total == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string name);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1;
      check(name, exp, rdata_o);
      @(posedge ref_clk_i);
      #1;
      check("rdata_idle", 32'h0000_0000, rdata_o);
   endtask : rd
   task automatic do_reset;
      @(posedge ref_clk_i);
      rate_cfg <= code;
      rx_cfg <= code[0];
      tx_cfg <= code[1];
      width_cfg <= w;
      // Straps wobble right after the minimum hold, so a late sample shows
      disturb <= 1'b1;
      reset_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      #1;
      check("rate_in_reset", 32'h0000_0002, 32'(port_rate_o));
      check("lanes_in_reset", 32'h00ff_0000, 32'({four_lane_o, rx_rev, tx_rev}));
      check("valid_oe_in_reset", 32'h0000_0000, 32'({straps_valid_o, strap_oe}));
      @(posedge ref_clk_i);
      reset_i <= 1'b0;
      // Capture lands well inside the bound; a hang ends the run
      for (n = 0; n < 40 && straps_valid_o !== 1'b1; n++) begin
         @(posedge ref_clk_i);
         #1;
      end
      if (n == 40) begin
         err_total++;
         $display("ERROR straps_valid expected 1 seen %b", straps_valid_o);
         print_verdict;
      end
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask : do_reset
   // ---------------------------------------------------------------
   // Main sequence: every rate code, lane straps and width patterns
   // ---------------------------------------------------------------
   initial begin
      for (int i = 0; i < 4; i++) begin
         code = 2'(i);
         w = width_tbl[i];
         exp_rate = (code == 2'h3) ? 2'h2 : code;
         do_reset;
         check("port_rate", 32'(exp_rate), 32'(port_rate_o));
         check("four_lane", {24'h00_0000, ~w}, 32'(four_lane_o));
         check("rx_rev", {24'h00_0000, code[0] ? ~w : 8'h00}, 32'(rx_rev));
         check("tx_rev", {24'h00_0000, code[1] ? ~w : 8'h00}, 32'(tx_rev));
         rd(`ADDR_STRAP_STAT, {26'h000_0000, exp_rate, code[1], code[0], (code == 2'h3), 1'h1}, "status");
         rd(`ADDR_LANE_CFG, 32'(w), "lane_cfg");
         @(posedge ref_clk_i);
         disturb <= 1'b1;
         repeat (20) @(posedge ref_clk_i);
         #1;
         check("held_rate", 32'(exp_rate), 32'(port_rate_o));
         check("held_lanes", 32'({four_lane_o, rx_rev}), 32'({~w, code[0] ? ~w : 8'h00}));
         wr(`ADDR_CLK_SEL, 32'h0000_0001);
         check("sw_rate", 32'h0000_0001, 32'(port_rate_o));
         rd(`ADDR_CLK_SEL, 32'h0000_0001, "clk_sel");
         wr(`ADDR_CLK_SEL, 32'h0000_0003);
         check("refused_rate", 32'h0000_0001, 32'(port_rate_o));
         rd(4'hf, 32'h0000_0000, "unmapped");
         @(posedge ref_clk_i);
         self_reset_done_i <= 1'b1;
         @(posedge ref_clk_i);
         self_reset_done_i <= 1'b0;
         repeat (2) @(posedge ref_clk_i);
         #1;
         check("self_reset_rate", 32'(exp_rate), 32'(port_rate_o));
         check("oe_normal", 32'h0000_0000, 32'(strap_oe));
         @(posedge ref_clk_i);
         test_mode_i <= 1'b1;
         repeat (2) @(posedge ref_clk_i);
         #1;
         check("oe_test", 32'h0000_0003, 32'(strap_oe));
         check("pin_echo", 32'(exp_rate), 32'(strap_o));
         check("rate_in_test", 32'(exp_rate), 32'(port_rate_o));
         @(posedge ref_clk_i);
         test_mode_i <= 1'b0;
         repeat (2) @(posedge ref_clk_i);
         #1;
         check("oe_released", 32'h0000_0000, 32'(strap_oe));
      end
      print_verdict;
   end
endmodule : serial_port_strap_sampler_tb

// >>> bench/strap_board_model.sv
// Board tie-offs and two-way rate pin resolution facing the strap sampler
`timescale 1ns/1ps
module strap_board_model #(
   parameter int PAIRS = 8,
   parameter int HOLD  = 10
) (
   input  wire logic             ref_clk_i,   // Register bus clock
   input  wire logic             reset_i,     // Hard reset, active high
   input  wire logic [1:0]       rate_cfg_i,  // Rate tie-off level
   input  wire logic             rx_cfg_i,    // Rx reverse tie-off
   input  wire logic             tx_cfg_i,    // Tx reverse tie-off
   input  wire logic [PAIRS-1:0] width_cfg_i, // Width tie-offs
   input  wire logic             disturb_i,   // Wobble straps after hold
   input  wire logic [1:0]       rate_drv_i,  // Device rate pin value
   input  wire logic [1:0]       rate_oe_i,   // Device rate pin enable
   output logic [1:0]            rate_pin_o,  // Resolved rate pin level
   output logic                  rx_pin_o,    // Rx reverse pin
   output logic                  tx_pin_o,    // Tx reverse pin
   output logic [PAIRS-1:0]      width_pin_o  // Width pins
);
   // ---------------------------------------------------------------
   // Hold window after release
   // ---------------------------------------------------------------
   int unsigned since_rel;
   logic        wob;
   logic        flip;
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         since_rel <= 0;
         wob       <= 1'b1;
      end else begin
         wob <= ~wob;
         if (since_rel < HOLD) begin
            since_rel <= since_rel + 1;
         end
      end
   end
   // Steady for the minimum hold only; later toggles expose a late sample
   assign flip = disturb_i && !reset_i && (since_rel >= HOLD) && wob;
   // ---------------------------------------------------------------
   // Pin levels
   // ---------------------------------------------------------------
   always_comb begin
      for (int b = 0; b < 2; b++) begin
         // Tie-off reads 11 only when the bench asks for it or a wobble flips a 00 tie-off
         rate_pin_o[b] = rate_oe_i[b] ? rate_drv_i[b] : (rate_cfg_i[b] ^ flip);
      end
   end
   assign rx_pin_o    = rx_cfg_i ^ flip;
   assign tx_pin_o    = tx_cfg_i ^ flip;
   assign width_pin_o = width_cfg_i ^ {PAIRS{flip}};
endmodule : strap_board_model

// >>> rtl/serial_port_strap_sampler.sv
// Reset-time capture of serial port straps with software rate override
`timescale 1ns/1ps
`include "strap_params.svh"
module serial_port_strap_sampler
   import strap_pkg::*;
#(
   parameter int PAIRS = 8
) (
   input  wire logic             ref_clk_i,                 // Register bus clock
   input  wire logic             reset_i,                   // Hard reset, active high
   input  wire logic             self_reset_done_i,         // Self-reset completed pulse
   input  wire logic             test_mode_i,               // Test mode enable
   input  wire logic [1:0]       port_line_rate_strap_i,    // Rate strap pins in
   output logic [1:0]            port_line_rate_strap_o,    // Rate strap pins out
   output logic [1:0]            port_line_rate_strap_oe_o, // Rate strap drive enable
   input  wire logic             rx_lane_reverse_strap_i,   // Receive reverse strap
   input  wire logic             tx_lane_reverse_strap_i,   // Transmit reverse strap
   input  wire logic [PAIRS-1:0] port_width_strap_i,        // Width strap per pair
   input  wire logic [3:0]       addr_i,                    // Register address
   input  wire logic [31:0]      wdata_i,                   // Write data
   input  wire logic             wr_i,                      // Write strobe
   input  wire logic             rd_i,                      // Read strobe
   output logic [31:0]           rdata_o,                   // Read data, next cycle
   output logic [1:0]            port_rate_o,               // Active line rate
   output logic [PAIRS-1:0]      rx_lane_reverse_o,         // Rx reversal per even port
   output logic [PAIRS-1:0]      tx_lane_reverse_o,         // Tx reversal per even port
   output logic [PAIRS-1:0]      four_lane_o,               // Pair runs four-lane
   output logic                  straps_valid_o             // Straps captured
);
   localparam int SW = PAIRS + 4;

   // ------------------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------------------
   strap_sync_if #(.WIDTH(SW)) sync_bus ();
   assign sync_bus.raw = {port_width_strap_i, tx_lane_reverse_strap_i,
                          rx_lane_reverse_strap_i, port_line_rate_strap_i};

   strap_pin_sync #(.WIDTH(SW)) u_sync (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .pins      (sync_bus)
   );

   // ------------------------------------------------------------------------
   // Capture sequencing
   // ------------------------------------------------------------------------
   capture_state_t   state;
   logic [3:0]       stable_cnt;
   logic [1:0]       cap_rate;
   logic             cap_rx;
   logic             cap_tx;
   logic [PAIRS-1:0] cap_width;
   logic             captured;
   logic             illegal;
   logic [1:0]       rate_reg;
   logic             rd_q;
   logic [31:0]      next_rdata;

   // Wait out the pin sync pipeline, then count the stability window
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state      <= st_wait;
         stable_cnt <= 4'h0;
      end else begin
         case (state)
            st_wait: begin
               stable_cnt <= stable_cnt + 4'h1;
               if (stable_cnt == 4'(`SYNC_STAGES)) begin
                  state      <= st_count;
                  stable_cnt <= 4'h0;
               end
            end
            st_count: begin
               stable_cnt <= stable_cnt + 4'h1;
               if (stable_cnt == `STABLE_CYCLES - 4'h1) begin // RQ4
                  state <= st_held;
               end
            end
            st_held: stable_cnt <= stable_cnt;
            default: state <= st_wait;
         endcase
      end
   end

   assign captured = (state == st_held);

   // Sample once at window end; nothing later changes the holding flops
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         cap_rate  <= `RATE_RESET;
         cap_rx    <= 1'b0;
         cap_tx    <= 1'b0;
         cap_width <= '0;
         illegal   <= 1'b0;
      end else if (state == st_count && stable_cnt == `STABLE_CYCLES - 4'h1) begin // RQ14
         cap_rx    <= sync_bus.stable[2]; // RQ9
         cap_tx    <= sync_bus.stable[3]; // RQ9
         cap_width <= sync_bus.stable[SW-1:4]; // RQ13
         // Illegal code falls back to the default rate
         if (sync_bus.stable[1:0] == `RATE_ILLEGAL) begin // RQ2
            cap_rate <= `RATE_RESET;
            illegal  <= 1'b1;
         end else begin
            cap_rate <= sync_bus.stable[1:0]; // RQ1
         end
      end
   end

   // ------------------------------------------------------------------------
   // Active rate: strap once captured and at self-reset completion, software otherwise
   // ------------------------------------------------------------------------
   logic apply_pending;
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rate_reg      <= `RATE_RESET;
         apply_pending <= 1'b1;
      end else if (state == st_count && stable_cnt == `STABLE_CYCLES - 4'h1) begin
         apply_pending <= 1'b1;
      end else if (apply_pending && captured) begin
         rate_reg      <= cap_rate; // RQ3
         apply_pending <= 1'b0;
      end else if (self_reset_done_i && captured) begin
         rate_reg <= cap_rate; // RQ3
      end else if (wr_i && addr_i == `ADDR_CLK_SEL && wdata_i[1:0] != `RATE_ILLEGAL) begin
         rate_reg <= wdata_i[`CLK_SEL_RATE_LSB +: 2]; // RQ5
      end
   end

   assign port_rate_o    = rate_reg;
   assign straps_valid_o = captured;

   // ------------------------------------------------------------------------
   // Lane order per even-numbered port
   // ------------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < PAIRS; g++) begin : g_pair
         always_ff @(posedge ref_clk_i) begin
            if (reset_i) begin
               rx_lane_reverse_o[g] <= 1'b0;
               tx_lane_reverse_o[g] <= 1'b0;
               four_lane_o[g]       <= 1'b1;
            end else if (captured) begin
               four_lane_o[g]       <= ~cap_width[g]; // RQ13
               // Reversal is only meaningful on a four-lane pair
               rx_lane_reverse_o[g] <= cap_rx & ~cap_width[g]; // RQ6 RQ8
               tx_lane_reverse_o[g] <= cap_tx & ~cap_width[g]; // RQ7 RQ10
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------------
   // Test mode drive of the rate pins
   // ------------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         port_line_rate_strap_o    <= 2'b00;
         port_line_rate_strap_oe_o <= 2'b00;
      end else begin
         port_line_rate_strap_o    <= rate_reg;
         port_line_rate_strap_oe_o <= {2{test_mode_i}}; // RQ12
      end
   end

   // ------------------------------------------------------------------------
   // Register read port, clocked by the register bus clock
   // ------------------------------------------------------------------------
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (addr_i)
         `ADDR_CLK_SEL: next_rdata[1:0] = rate_reg;
         `ADDR_STRAP_STAT: begin
            next_rdata[`STAT_DONE_BIT]          = captured;
            next_rdata[`STAT_ILLEGAL_BIT]       = illegal;
            next_rdata[`STAT_RXREV_BIT]         = cap_rx;
            next_rdata[`STAT_TXREV_BIT]         = cap_tx;
            next_rdata[`STAT_CAP_LSB +: 2]      = cap_rate;
         end
         `ADDR_LANE_CFG: next_rdata[PAIRS-1:0] = cap_width;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin // RQ11
      if (reset_i) begin
         rdata_o <= 32'h0000_0000;
         rd_q    <= 1'b0;
      end else begin
         rd_q    <= rd_i;
         rdata_o <= rd_i ? next_rdata : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   int unsigned since_rst;
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) since_rst <= 0;
      else if (since_rst < 1000) since_rst <= since_rst + 1;
   end

   property p_capture_time;
      @(posedge ref_clk_i) disable iff (reset_i)
         (since_rst == 15) |-> captured;
   endproperty
   a_capture_time: assert property (p_capture_time) else $error("late capture"); // RQ14

   property p_not_early;
      @(posedge ref_clk_i) disable iff (reset_i)
         (since_rst < 14) |-> !captured;
   endproperty
   a_not_early: assert property (p_not_early) else $error("early capture"); // RQ4

   property p_held;
      @(posedge ref_clk_i) disable iff (reset_i)
         captured |=> $stable(cap_rate) && $stable(cap_rx) && $stable(cap_tx);
   endproperty
   a_held: assert property (p_held) else $error("strap changed after capture"); // RQ9

   property p_no_illegal;
      @(posedge ref_clk_i) disable iff (reset_i)
         rate_reg != `RATE_ILLEGAL;
   endproperty
   a_no_illegal: assert property (p_no_illegal) else $error("illegal rate"); // RQ2

   property p_apply;
      @(posedge ref_clk_i) disable iff (reset_i)
         $rose(captured) |=> (rate_reg == cap_rate);
   endproperty
   a_apply: assert property (p_apply) else $error("rate not applied"); // RQ3

   property p_sw_write;
      @(posedge ref_clk_i) disable iff (reset_i)
         (captured && !apply_pending && !self_reset_done_i && wr_i
          && addr_i == `ADDR_CLK_SEL && wdata_i[1:0] != `RATE_ILLEGAL)
         |=> rate_reg == $past(wdata_i[1:0]);
   endproperty
   a_sw_write: assert property (p_sw_write) else $error("override lost"); // RQ5

   property p_rx_single;
      @(posedge ref_clk_i) disable iff (reset_i)
         !four_lane_o[0] |-> !rx_lane_reverse_o[0];
   endproperty
   a_rx_single: assert property (p_rx_single) else $error("rx reverse in 1x"); // RQ8

   property p_tx_four;
      @(posedge ref_clk_i) disable iff (reset_i)
         tx_lane_reverse_o[0] |-> four_lane_o[0];
   endproperty
   a_tx_four: assert property (p_tx_four) else $error("tx reverse not 4x"); // RQ10

   property p_oe;
      @(posedge ref_clk_i) disable iff (reset_i)
         test_mode_i ##1 1'b1 |-> &port_line_rate_strap_oe_o;
   endproperty
   a_oe: assert property (p_oe) else $error("test drive missing"); // RQ12

   property p_oe_off;
      @(posedge ref_clk_i) disable iff (reset_i)
         !test_mode_i |=> port_line_rate_strap_oe_o == 2'b00;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("drive outside test"); // RQ12

   property p_read;
      @(posedge ref_clk_i) disable iff (reset_i)
         rd_i && addr_i == `ADDR_CLK_SEL |=> rdata_o[1:0] == $past(rate_reg);
   endproperty
   a_read: assert property (p_read) else $error("bad read"); // RQ11

   // Read data stands for one cycle only, zero otherwise
   property p_rdata_idle;
      @(posedge ref_clk_i) disable iff (reset_i)
         !rd_q |-> rdata_o == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("stale read data"); // RQ11

   c_capture: cover property (@(posedge ref_clk_i) $rose(captured));
   c_selfrst: cover property (@(posedge ref_clk_i) captured && self_reset_done_i);
   c_write:   cover property (@(posedge ref_clk_i) captured && wr_i && addr_i == `ADDR_CLK_SEL);
   c_rev:     cover property (@(posedge ref_clk_i) rx_lane_reverse_o[0]);
   c_settled: cover property (@(posedge ref_clk_i) sync_bus.settled && $rose(captured));
endmodule : serial_port_strap_sampler

// >>> rtl/strap_params.svh
// Constants for the serial port strap sampler
// How it works
// RQ1: Rate strap 00 is 1.25, 01 is 2.5, 10 is 3.125 Gbit/s.
// RQ2: Code 10 is default; code 11 is illegal, board never presents it.
// RQ3: Strapped rate is applied at hard reset release and self-reset completion.
// RQ4: Board holds rate straps steady ten bus clocks after hard reset release.
// RQ5: Straps ignored after reset; captured rate readable and writable by software.
// RQ6: Receive reverse strap flips lane order on even four-lane ports.
// RQ7: Transmit reverse strap flips lane order on even four-lane ports.
// RQ8: Receive reverse strap is disregarded for single-lane port pairs.
// RQ9: Both reverse straps sampled after ten stable cycles, then ignored.
// RQ10: Reversed ports work only in four-lane mode.
// RQ11: Register bus runs on the dedicated register-bus clock.
// RQ12: Rate strap pins are driven only in test mode.
// RQ13: Width strap 0 gives four-lane port n, 1 gives two single-lane ports.
// RQ14: Straps latch once the stability window elapses, held until next reset.
`ifndef STRAP_PARAMS_SVH
`define STRAP_PARAMS_SVH

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define STABLE_CYCLES      4'd10
`define SYNC_STAGES        3

// ---------------------------------------------------------------------------
// Line rate codes
// ---------------------------------------------------------------------------
`define RATE_1G25          2'b00
`define RATE_2G5           2'b01
`define RATE_3G125         2'b10
`define RATE_ILLEGAL       2'b11
`define RATE_RESET         2'b10

// ---------------------------------------------------------------------------
// Register map, word offsets
// ---------------------------------------------------------------------------
`define ADDR_CLK_SEL       4'h0
`define ADDR_STRAP_STAT    4'h1
`define ADDR_LANE_CFG      4'h2
`define CLK_SEL_RATE_LSB   0
`define STAT_DONE_BIT      0
`define STAT_ILLEGAL_BIT   1
`define STAT_RXREV_BIT     2
`define STAT_TXREV_BIT     3
`define STAT_CAP_LSB       4

`endif

// >>> rtl/strap_pin_sync.sv
// Three-stage pin synchroniser with agreement detect
`timescale 1ns/1ps
module strap_pin_sync #(
   parameter int WIDTH = 4
) (
   input  wire logic   ref_clk_i,     // Register bus clock
   input  wire logic   reset_i,       // Sync reset, active high
   strap_sync_if.sync  pins           // Raw in, stable out
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;

   // Change counts once stages two and three agree
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         s1           <= '0;
         s2           <= '0;
         s3           <= '0;
         pins.stable  <= '0;
         pins.settled <= 1'b0;
      end else begin
         s1           <= pins.raw;
         s2           <= s1;
         s3           <= s2;
         pins.settled <= (s2 == s3);
         if (s2 == s3) begin
            pins.stable <= s3;
         end
      end
   end
endmodule : strap_pin_sync

// >>> rtl/strap_pkg.sv
// Types for the serial port strap sampler
package strap_pkg;
   typedef enum logic [1:0] {
      rate_1g25,
      rate_2g5,
      rate_3g125,
      rate_illegal
   } line_rate_t;
   typedef enum {
      st_wait,
      st_count,
      st_held
   } capture_state_t;
endpackage : strap_pkg

// >>> rtl/strap_sync_if.sv
// Synchroniser bundle between top and pin synchroniser
`timescale 1ns/1ps
interface strap_sync_if #(parameter int WIDTH = 4);
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] stable;
   logic             settled;
   modport top  (output raw, input stable, input settled);
   modport sync (input raw, output stable, output settled);
endinterface : strap_sync_if
